// ---- src/mpu_pkg.sv ----
// Shared types and constants for the memory panel updater
package mpu_pkg;

   // ***************************************************************
   // Timing parameter slots
   // ***************************************************************
   localparam int TP_CMD = 0;
   localparam int TP_LEAD = 0;
   localparam int TP_LAG = 1;
   localparam int TP_DUMMY = 1;
   localparam int TP_XFER = 2;
   localparam int TP_MODE = 3;
   localparam int TP_MODE_CNT = 4;
   localparam int TP_ADDR_CNT = 5;
   localparam int TP_GAP = 6;
   localparam int TP_COUNT = 16;

   // ***************************************************************
   // Link encodings and symbol sizes
   // ***************************************************************
   localparam int LINK_SERIAL_BIT = 1;
   localparam logic [1:0] LINK_3W = 2'h2;
   localparam logic [1:0] LINK_4W = 2'h3;
   localparam logic [4:0] BITS_PAR = 5'h01;
   localparam logic [4:0] BITS_4W = 5'h08;
   localparam logic [4:0] BITS_3W = 5'h09;
   localparam logic [4:0] BITS_SPI_BYTE = 5'h08;
   localparam logic [3:0] MODE_FIELD_W = 4'h8;
   localparam logic [4:0] ADDR_FIELD_W = 5'h10;
   localparam int ALPHA_MSB = 15;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic RST_SELECT = 1'h0;
   localparam logic RST_STROBE_N = 1'h1;

   typedef enum logic [3:0] {
      S_IDLE, S_LEAD, S_LOAD, S_FETCH, S_SHIFT, S_LAG, S_GAP, S_DONE
   } mpu_state_e;

   typedef enum logic [2:0] {
      PH_MODE, PH_ADDR, PH_PIX, PH_CMD, PH_PARAM, PH_DUMMY
   } mpu_phase_e;

   typedef logic [TP_COUNT-1:0][7:0] mpu_tim_t;

   typedef struct packed {
      logic gray_panel_select;
      logic select_polarity;
      logic [7:0] timing_divider;
      logic [9:0] panel_width;
      logic [9:0] panel_height;
      logic [31:0] image_base_address;
      logic [9:0] image_row_pitch;
      logic [9:0] first_update_line;
      logic [9:0] last_update_line;
      logic update_function_select;
      logic [3:0] parameter_count;
      logic [1:0] gray_link_type;
      logic [1:0] gray_pixel_depth;
      logic gray_alpha_enable;
      logic pixel_invert;
   } mpu_cfg_s;

   typedef struct packed {
      logic panel_select;
      logic serial_clk;
      logic gray_serial_data;
      logic cmd_param_select;
      logic write_strobe_n;
      logic read_strobe_n;
      logic [7:0] gray_data;
   } mpu_pins_s;

endpackage

// ---- src/mpu_unit_timer.sv ----
// Panel timing unit counter with clock phase output
`timescale 1ns/1ps
`default_nettype none

module mpu_unit_timer (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic [7:0] divider,
   output logic unit_last,
   output logic low_phase
);

   logic [7:0] cnt_r;
   logic [8:0] half;

   // ***************************************************************
   // One unit is divider plus one system clocks
   // ***************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 8'h00;
      end else if (clear || cnt_r >= divider) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // Low half rounds down, so an even divider leaves the high half longer
   assign half = ({1'b0, divider} + 9'h001) >> 1;
   assign low_phase = clear || ({1'b0, cnt_r} < half);
   assign unit_last = !clear && (cnt_r >= divider);

endmodule // mpu_unit_timer

`default_nettype wire

// ---- src/mpu_updater.sv ----
// Memory panel updater: SPI and grayscale panel sequencer
`timescale 1ns/1ps
`default_nettype none

module mpu_updater
   import mpu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire mpu_cfg_s cfg,
   input wire mpu_tim_t timing_param,
   input wire logic update_trigger_set,
   input wire logic update_done_clear,
   input wire logic update_irq_enable,
   output logic update_trigger,
   output logic update_done_flag,
   output logic update_irq,
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output mpu_pins_s panel
);

   mpu_state_e state_r;
   mpu_phase_e phase_r;
   logic [9:0] line_r;
   logic [9:0] col_r;
   logic [7:0] wait_r;
   logic [4:0] bits_r;
   logic [15:0] sh_r;
   logic dc_r;
   logic sel_act_r;
   logic [8:0] xfer_r;
   logic [3:0] param_r;
   logic [3:0] pix_k_r;
   logic [3:0] pix_n_r;
   logic [7:0] pix_byte_r;
   logic tmr_clr_r;
   logic unit_last;
   logic low_phase;
   logic gray;
   logic serial;
   logic [9:0] last_eff;
   logic [3:0] bw;
   logic [3:0] ppb;
   logic [4:0] gbits;
   logic [10:0] f_row;
   logic [9:0] f_col;
   logic [21:0] row_off;
   logic f_skip;
   logic [7:0] px_raw;
   logic [7:0] px;
   logic [3:0] slot;
   logic [7:0] ins;
   logic [9:0] spi_left;
   logic [10:0] next_band;

   function automatic logic [15:0] gray_frame(input logic [7:0] b, input logic dc,
                                              input logic [1:0] link);
      gray_frame = (link == LINK_3W) ? {dc, b, 7'h00} : {b, 8'h00};
   endfunction

   mpu_unit_timer u_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clear(tmr_clr_r),
      .divider(cfg.timing_divider),
      .unit_last(unit_last),
      .low_phase(low_phase)
   );

   // ***************************************************************
   // Decode of mode, depth and fetch position
   // ***************************************************************
   assign gray = cfg.gray_panel_select;
   assign serial = !gray || cfg.gray_link_type[LINK_SERIAL_BIT];
   assign last_eff = (cfg.last_update_line < cfg.panel_height) ?
                     cfg.last_update_line : cfg.panel_height - 10'h001;

   always_comb begin
      unique case (cfg.gray_pixel_depth)
         2'h0: begin bw = 4'h1; ppb = 4'h8; end
         2'h1: begin bw = 4'h2; ppb = 4'h4; end
         2'h2: begin bw = 4'h4; ppb = 4'h2; end
         2'h3: begin bw = 4'h8; ppb = 4'h1; end
      endcase
      if (!gray) begin
         bw = 4'h1;
      end
   end

   always_comb begin
      unique case (cfg.gray_link_type)
         LINK_3W: gbits = BITS_3W;
         LINK_4W: gbits = BITS_4W;
         default: gbits = BITS_PAR;
      endcase
   end

   // Grayscale walks down a band of rows, SPI walks across one line
   assign f_row = {1'b0, line_r} + (gray ? {7'h00, pix_k_r} : 11'h000);
   assign f_col = col_r + (gray ? 10'h000 : {6'h00, pix_k_r});
   assign row_off = f_row * {1'b0, cfg.image_row_pitch};
   assign f_skip = gray && (f_row > {1'b0, last_eff});
   assign spi_left = cfg.panel_width - col_r;
   assign next_band = {1'b0, line_r} + {7'h00, ppb};

   // Transparent pixels fall back to zero before inversion
   assign px_raw = (cfg.gray_alpha_enable && !mem_rdata[ALPHA_MSB]) ?
                   8'h00 : mem_rdata[7:0];
   assign px = (px_raw ^ {8{cfg.pixel_invert}}) >> (4'h8 - bw);
   // Upper row lands in the low bits of a grayscale byte
   assign slot = gray ? 4'(pix_k_r * bw) : 4'h7 - pix_k_r;
   assign ins = px << slot;

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= S_IDLE;
         phase_r <= PH_MODE;
         line_r <= 10'h000;
         col_r <= 10'h000;
         wait_r <= 8'h00;
         bits_r <= 5'h00;
         sh_r <= 16'h0000;
         dc_r <= 1'h0;
         sel_act_r <= 1'h0;
         xfer_r <= 9'h000;
         param_r <= 4'h0;
         pix_k_r <= 4'h0;
         pix_n_r <= 4'h0;
         pix_byte_r <= 8'h00;
         tmr_clr_r <= 1'h0;
         mem_req <= 1'h0;
         mem_addr <= 32'h0000_0000;
      end else begin
         tmr_clr_r <= 1'h0;
         unique case (state_r)
            S_IDLE: begin
               if (update_trigger) begin
                  line_r <= cfg.first_update_line;
                  col_r <= 10'h000;
                  param_r <= 4'h0;
                  xfer_r <= 9'h000;
                  tmr_clr_r <= 1'h1;
                  if (cfg.first_update_line > last_eff &&
                      !(gray && cfg.update_function_select)) begin
                     state_r <= S_DONE;
                  end else if (gray) begin
                     sel_act_r <= 1'h1;
                     phase_r <= PH_CMD;
                     state_r <= S_LOAD;
                  end else begin
                     sel_act_r <= 1'h1;
                     wait_r <= timing_param[TP_LEAD];
                     phase_r <= PH_MODE;
                     state_r <= S_LEAD;
                  end
               end
            end
            S_LEAD: begin
               if (wait_r == 8'h00) begin
                  state_r <= S_LOAD;
               end else if (unit_last) begin
                  wait_r <= wait_r - 8'h01;
               end
            end
            S_LOAD: begin
               tmr_clr_r <= 1'h1;
               unique case (phase_r)
                  PH_MODE: begin
                     phase_r <= PH_ADDR;
                     if (timing_param[TP_MODE_CNT][2:0] != 3'h0) begin
                        sh_r <= {timing_param[TP_MODE], 8'h00} <<
                                (MODE_FIELD_W - {1'b0, timing_param[TP_MODE_CNT][2:0]});
                        bits_r <= {2'h0, timing_param[TP_MODE_CNT][2:0]};
                        state_r <= S_SHIFT;
                     end
                  end
                  PH_ADDR: begin
                     phase_r <= PH_PIX;
                     if (timing_param[TP_ADDR_CNT][3:0] != 4'h0) begin
                        sh_r <= {6'h00, line_r} <<
                                (ADDR_FIELD_W - {1'b0, timing_param[TP_ADDR_CNT][3:0]});
                        bits_r <= {1'b0, timing_param[TP_ADDR_CNT][3:0]};
                        state_r <= S_SHIFT;
                     end
                  end
                  PH_CMD: begin
                     dc_r <= 1'h0;
                     sh_r <= gray_frame(timing_param[TP_CMD], 1'h0, cfg.gray_link_type);
                     bits_r <= gbits;
                     phase_r <= cfg.update_function_select ? PH_PARAM : PH_DUMMY;
                     state_r <= S_SHIFT;
                  end
                  PH_PARAM: begin
                     if (param_r < cfg.parameter_count) begin
                        dc_r <= 1'h1;
                        sh_r <= gray_frame(timing_param[param_r + 4'h1], 1'h1,
                                           cfg.gray_link_type);
                        bits_r <= gbits;
                        param_r <= param_r + 4'h1;
                        state_r <= S_SHIFT;
                     end else begin
                        state_r <= S_DONE;
                     end
                  end
                  PH_DUMMY: begin
                     dc_r <= 1'h1;
                     sh_r <= gray_frame(timing_param[TP_DUMMY], 1'h1, cfg.gray_link_type);
                     bits_r <= gbits;
                     phase_r <= PH_PIX;
                     state_r <= S_SHIFT;
                  end
                  PH_PIX: begin
                     if (col_r < cfg.panel_width) begin
                        pix_k_r <= 4'h0;
                        pix_byte_r <= 8'h00;
                        pix_n_r <= gray ? ppb :
                                   (spi_left >= 10'h008 ? 4'h8 : spi_left[3:0]);
                        state_r <= S_FETCH;
                     end else if (gray) begin
                        col_r <= 10'h000;
                        line_r <= next_band[9:0];
                        if (next_band > {1'b0, last_eff}) begin
                           state_r <= S_DONE;
                        end
                     end else if (xfer_r < {1'b0, timing_param[TP_XFER]}) begin
                        sh_r <= 16'h0000;
                        bits_r <= 5'h01;
                        state_r <= S_SHIFT;
                     end else begin
                        wait_r <= timing_param[TP_LAG];
                        state_r <= S_LAG;
                     end
                  end
               endcase
            end
            S_FETCH: begin
               if (pix_k_r == pix_n_r) begin
                  tmr_clr_r <= 1'h1;
                  sh_r <= gray ? gray_frame(pix_byte_r, 1'h1, cfg.gray_link_type) :
                          {pix_byte_r, 8'h00};
                  bits_r <= gray ? gbits : {1'b0, pix_n_r};
                  col_r <= col_r + (gray ? 10'h001 : {6'h00, pix_n_r});
                  state_r <= S_SHIFT;
               end else if (f_skip) begin
                  pix_k_r <= pix_k_r + 4'h1;
               end else if (!mem_req) begin
                  mem_req <= 1'h1;
                  mem_addr <= cfg.image_base_address + {10'h000, row_off} +
                              {22'h000000, f_col};
               end else if (mem_ack) begin
                  mem_req <= 1'h0;
                  pix_byte_r <= pix_byte_r | ins;
                  pix_k_r <= pix_k_r + 4'h1;
               end
            end
            S_SHIFT: begin
               if (unit_last) begin
                  sh_r <= sh_r << 1;
                  bits_r <= bits_r - 5'h01;
                  if (!gray) begin
                     xfer_r <= xfer_r + 9'h001;
                  end
                  if (bits_r == 5'h01) begin
                     state_r <= S_LOAD;
                  end
               end
            end
            S_LAG: begin
               if (wait_r == 8'h00) begin
                  sel_act_r <= 1'h0;
                  tmr_clr_r <= 1'h1;
                  if (line_r < last_eff) begin
                     line_r <= line_r + 10'h001;
                     col_r <= 10'h000;
                     xfer_r <= 9'h000;
                     phase_r <= PH_MODE;
                     wait_r <= timing_param[TP_GAP];
                     state_r <= S_GAP;
                  end else begin
                     state_r <= S_DONE;
                  end
               end else if (unit_last) begin
                  wait_r <= wait_r - 8'h01;
               end
            end
            S_GAP: begin
               if (wait_r == 8'h00) begin
                  sel_act_r <= 1'h1;
                  tmr_clr_r <= 1'h1;
                  wait_r <= timing_param[TP_LEAD];
                  state_r <= S_LEAD;
               end else if (unit_last) begin
                  wait_r <= wait_r - 8'h01;
               end
            end
            S_DONE: begin
               sel_act_r <= 1'h0;
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Trigger, done flag and interrupt
   // ***************************************************************
   // A trigger written in the completion cycle survives and starts again
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         update_trigger <= 1'h0;
      end else if (update_trigger_set) begin
         update_trigger <= 1'h1;
      end else if (state_r == S_DONE) begin
         update_trigger <= 1'h0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         update_done_flag <= 1'h0;
      end else if (state_r == S_DONE) begin
         update_done_flag <= 1'h1;
      end else if (update_done_clear) begin
         update_done_flag <= 1'h0;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         update_irq <= 1'h0;
      end else begin
         update_irq <= update_done_flag && update_irq_enable;
      end
   end

   // ***************************************************************
   // Panel pins, registered
   // ***************************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         panel.panel_select <= RST_SELECT;
         panel.serial_clk <= 1'h0;
         panel.gray_serial_data <= 1'h0;
         panel.cmd_param_select <= 1'h0;
         panel.write_strobe_n <= RST_STROBE_N;
         panel.read_strobe_n <= RST_STROBE_N;
         panel.gray_data <= 8'h00;
      end else begin
         panel.panel_select <= gray ? (sel_act_r ^ !cfg.select_polarity) :
                               (sel_act_r ^ cfg.select_polarity);
         panel.serial_clk <= serial && state_r == S_SHIFT && !low_phase;
         panel.gray_serial_data <= serial && state_r == S_SHIFT && sh_r[15];
         panel.cmd_param_select <= gray && dc_r;
         // Reads from the panel are not supported, so the read strobe idles
         panel.read_strobe_n <= RST_STROBE_N;
         panel.write_strobe_n <= !(!serial && state_r == S_SHIFT && low_phase);
         panel.gray_data <= serial ? 8'h00 : sh_r[15:8];
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   AST_SPI_SELECT_HIGH: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == S_SHIFT && !gray && !cfg.select_polarity) |=> panel.panel_select)
      else $error("SPI select not active high");

   AST_GRAY_SELECT_LOW: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == S_SHIFT && gray && !cfg.select_polarity) |=> !panel.panel_select)
      else $error("Grayscale select not active low");

   AST_CMD_DC_LOW: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == S_LOAD && phase_r == PH_CMD) |=> ##1 !panel.cmd_param_select)
      else $error("Command byte sent with select high");

   AST_PARAM_DC_HIGH: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == S_SHIFT && gray &&
       (phase_r == PH_PIX || (phase_r == PH_PARAM && param_r != 4'h0)))
      |=> panel.cmd_param_select)
      else $error("Parameter byte sent with select low");

   AST_EVEN_DIV_HIGH: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      ($rose(panel.serial_clk) && cfg.timing_divider == 8'h02 && state_r == S_SHIFT)
      |=> panel.serial_clk ##1 !panel.serial_clk)
      else $error("Serial clock high phase wrong for even divider");

   AST_DONE_EFFECTS: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == S_DONE && !update_trigger_set) |=> (!update_trigger && update_done_flag))
      else $error("Completion did not clear trigger and set flag");

   AST_TRIGGER_STARTS: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == S_IDLE && update_trigger_set) |-> ##2 (state_r != S_IDLE))
      else $error("Trigger did not start a sequence");

   AST_IRQ_GATED: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (!update_irq_enable ##1 !update_irq_enable) |-> !update_irq)
      else $error("Interrupt raised while disabled");

   AST_FLAG_CLEAR: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (update_done_clear && state_r != S_DONE) |=> !update_done_flag ##1 !update_irq)
      else $error("Done flag not cleared by write");

   AST_LINE_RANGE: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      (state_r == S_FETCH && !(gray && cfg.update_function_select))
      |-> (line_r >= cfg.first_update_line && line_r <= last_eff))
      else $error("Line outside update range");

endmodule // mpu_updater

`default_nettype wire

// ---- verification/mpu_fb_model.sv ----
// Frame-buffer memory model for the updater's pixel reads
`timescale 1ns/1ps
`default_nettype none
module mpu_fb_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   logic slow_r;
   logic take;
   // Alternate prompt and one-cycle-late answers
   assign take = mem_req && !mem_ack && slow_r;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_ack <= 1'h0;
         slow_r <= 1'h0;
         mem_rdata <= 16'h0000;
      end else begin
         slow_r <= ~slow_r;
         mem_ack <= take;
         // Off the ack the data keeps changing so stale reads show up
         mem_rdata <= take ? {8'h00, {8{mem_addr[0] ^ mem_addr[2]}}} : ~mem_rdata;
      end
   end
endmodule // mpu_fb_model
`default_nettype wire

// ---- verification/memory_panel_updater_tb.sv ----
// Self-checking bench for the memory panel updater
`timescale 1ns/1ps
`default_nettype none
module memory_panel_updater_tb;
   import mpu_pkg::*;
   typedef struct packed {
      logic func;
      logic [1:0] link;
      logic [1:0] depth;
      logic [9:0] height;
      logic [3:0] cnt;
      logic [3:0][8:0] exp;
   } mpu_row_s;
   logic sys_clk, sys_rst, trig, clr, irq_en, mem_req, mem_ack, strobe_q;
   logic update_trigger, update_done_flag, update_irq;
   logic [31:0] mem_addr;
   logic [15:0] mem_rdata;
   mpu_cfg_s cfg;
   mpu_tim_t timing_param;
   mpu_pins_s panel;
   logic [8:0] got[$];
   int err_total, tests_run, n;
   logic clk_q, booster_fast_response, regulator_economy;
   logic [3:0] bit_n;
   logic [3:0] frame_w;
   logic [8:0] sh_q;
   // SPI line bytes: mode 101, four address bits, two pixels, zeros to sixteen clocks
   logic [3:0][8:0] spi_exp = {9'h000, 9'h0A5, 9'h080, 9'h0A2};
   // Low 8 bits are the byte, bit 8 the command/parameter select
   mpu_row_s rows[6] = '{
      '{1'b1, 2'h0, 2'h0, 10'h008, 4'h2, {9'h000, 9'h1C3, 9'h13C, 9'h0A5}},
      '{1'b0, 2'h0, 2'h0, 10'h008, 4'h0, {9'h133, 9'h1CC, 9'h13C, 9'h0A5}},
      '{1'b0, 2'h1, 2'h1, 10'h004, 4'h0, {9'h10F, 9'h1F0, 9'h13C, 9'h0A5}},
      '{1'b1, 2'h1, 2'h0, 10'h008, 4'h0, {27'h0, 9'h0A5}},
      '{1'b0, 2'h2, 2'h0, 10'h008, 4'h0, {9'h133, 9'h1CC, 9'h13C, 9'h0A5}},
      '{1'b1, 2'h3, 2'h0, 10'h008, 4'h2, {9'h000, 9'h1C3, 9'h13C, 9'h0A5}}};
   // Three-wire frames carry the select bit in front of the byte
   assign frame_w = (cfg.gray_panel_select && cfg.gray_link_type == LINK_3W) ?
                    4'h9 : 4'h8;
   mpu_updater mpu_updater_i (.sys_clk, .sys_rst, .cfg, .timing_param,
      .update_trigger_set(trig), .update_done_clear(clr), .update_irq_enable(irq_en),
      .update_trigger, .update_done_flag, .update_irq, .mem_req, .mem_addr, .mem_ack,
      .mem_rdata, .panel);
   mpu_fb_model mpu_fb_model_i (.sys_clk, .sys_rst, .mem_req, .mem_addr, .mem_ack,
      .mem_rdata);
   initial begin
      sys_clk = 0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Parallel bytes are taken as the write strobe returns high
   always @(posedge sys_clk) begin
      if (!strobe_q && panel.write_strobe_n) begin
         got.push_back({panel.cmd_param_select, panel.gray_data});
      end
      strobe_q <= panel.write_strobe_n;
      // Serial bits are taken as the clock rises; an idle select restarts the count
      clk_q <= panel.serial_clk;
      if (panel.panel_select == cfg.gray_panel_select) begin
         bit_n <= 4'h0;
      end else if (!clk_q && panel.serial_clk) begin
         sh_q <= {sh_q[7:0], panel.gray_serial_data};
         bit_n <= (bit_n + 4'h1 == frame_w) ? 4'h0 : bit_n + 4'h1;
         if (bit_n + 4'h1 == frame_w) begin
            got.push_back(frame_w == 4'h9 ? {sh_q[7:0], panel.gray_serial_data} :
                          {panel.cmd_param_select, sh_q[6:0], panel.gray_serial_data});
         end
      end
   end
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic run();
      got.delete();
      booster_fast_response = 1;
      regulator_economy = 0;
      tick();
      trig = 1;
      tick();
      trig = 0;
      check(update_trigger, 9'h001);
      for (int i = 0; i < 3000 && !update_done_flag; i++) tick();
      check(update_done_flag, 9'h001);
      check(update_trigger, 9'h000);
      booster_fast_response = 0;
      regulator_economy = 1;
      tick();
      check(update_irq, {8'h00, irq_en});
      clr = 1;
      tick();
      clr = 0;
      check(update_done_flag, 9'h000);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      sys_rst = 1;
      trig = 0;
      clr = 0;
      irq_en = 1;
      timing_param = '0;
      timing_param[0] = 8'hA5;
      timing_param[1] = 8'h3C;
      timing_param[2] = 8'hC3;
      cfg = '0;
      cfg.gray_panel_select = 1;
      cfg.timing_divider = 8'h01;
      cfg.panel_width = 10'h002;
      cfg.image_row_pitch = 10'h002;
      cfg.last_update_line = 10'h007;
      repeat (20) @(posedge sys_clk);
      #1 sys_rst = 0;
      tick();
      check(panel.panel_select, 9'h001);
      check(panel.read_strobe_n, 9'h001);
      foreach (rows[k]) begin
         cfg.update_function_select = rows[k].func;
         cfg.gray_link_type = rows[k].link;
         cfg.gray_pixel_depth = rows[k].depth;
         cfg.panel_height = rows[k].height;
         cfg.parameter_count = rows[k].cnt;
         n = rows[k].func ? rows[k].cnt + 1 : 4;
         run();
         check(9'(got.size()), 9'(n));
         for (int j = 0; j < n && j < got.size(); j++) begin
            check(got[j], rows[k].exp[j]);
         end
      end
      // SPI lines 1 and 2 with an even divider, so the high phase runs long
      cfg.gray_panel_select = 0;
      cfg.timing_divider = 8'h02;
      cfg.panel_height = 10'h008;
      cfg.first_update_line = 10'h001;
      cfg.last_update_line = 10'h002;
      timing_param[6:0] = {8'h01, 8'h04, 8'h03, 8'h05, 8'h10, 8'h01, 8'h01};
      tick();
      check(panel.panel_select, 9'h000);
      run();
      check(9'(got.size()), 9'h004);
      for (int j = 0; j < 4 && j < got.size(); j++) begin
         check(got[j], spi_exp[j]);
      end
      irq_en = 0;
      cfg.first_update_line = 10'h009;
      tick();
      check(panel.panel_select, 9'h000);
      run();
      check(9'(got.size()), 9'h000);
      stop_test();
   end
   initial begin
      #1000000;
      err_total++;
      stop_test();
   end
endmodule // memory_panel_updater_tb
`default_nettype wire
